//--- beis_core.v
// bit error insertion and receive pattern checker status with wishbone registers
//
// The implementer's own choice: register access over Wishbone.
`include "beis_map.vh"

// Notes on behaviour
// (R1) single error insertion only happens while the single insert enable is set
// (R2) with source select 0, a rising soft strobe inverts exactly one transmit bit
// (R3) software must drop the strobe and raise it again for each further error
// (R4) several strobe toggles between two bit opportunities yield one error only
// (R5) source select 0 takes the soft strobe, 1 takes the manual insert input
// (R6) flipping source select while a trigger is high may cause one error
// (R7) update done rises once the counter snapshot update has completed
// (R8) update done is forced low when the selected update request falls
// (R9) count nonzero reads 1 while the bit error count is one or more
// (R10) count nonzero is cleared when software triggers a counter update
// (R11) pattern unlocked reads 1 while the checker is out of sync
// (R12) latched update done sets on a rising update done status bit
// (R13) latched error seen sets whenever the checker detects a bit error
// (R14) latched count nonzero sets on a rising count nonzero status bit
// (R15) latched unlock change sets on any change of the unlocked status bit
// (R16) update done interrupt requested when latched flag and its enable are set
// (R17) error seen interrupt needs its enable and the port status gate
// (R18) count nonzero interrupt needs its enable and the port status gate
// (R19) unlock interrupt needs its enable and the port status gate
// (R20) error counter is 24 bits, low 16 and high 8 in two registers
// (R21) counter saturates, holds while unlocked, readable value changes on update
// (R22) rate insertion inverts one in ten to the n bits, zero disables it
// (R23) latched flags stay set until software writes a one to clear
// (R24) one interrupt output ORs all enabled latched flags, the three status flags only while the port status gate is set

module beis_core (
	input  wire        ref_clk_i,
	input  wire        reset_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [31:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        tx_data_i,
	input  wire        tx_bit_en_i,
	output reg         tx_data_o,
	output reg         tx_valid_o,
	input  wire        manual_insert_input_i,
	input  wire        global_update_req_i,
	input  wire        pattern_unlocked_i,
	input  wire        rx_bit_en_i,
	input  wire        rx_bit_error_i,
	output reg         counter_update_request_o,
	output reg         irq_o
);

	// ============================================================
	// register state
	reg        insert_source_select;
	reg        soft_error_strobe;
	reg        single_insert_enable;
	reg [2:0]  insert_rate_exponent;
	reg        local_update_request;
	reg        update_mode_select;
	reg        port_status_irq_gate;
	reg [3:0]  irq_enable;
	reg [3:0]  latched;
	reg        counter_update_done;
	reg        error_count_nonzero;
	reg        pattern_unlocked;
	reg [23:0] live_count;
	reg [23:0] snap_count;

	// insertion and update request state
	reg        trigger_prev;
	reg        single_pending;
	reg [2:0]  active_rate;
	reg [2:0]  pending_rate;
	reg        rate_reload;
	reg [23:0] rate_count;
	reg        request_prev;
	reg        snap_taken;

	// ============================================================
	// bus decode
	wire       bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// writes land on the edge where the master sees ack
	wire       bus_done  = wb_cyc_i & wb_stb_i & wb_ack_o;
	wire       bus_wr    = bus_done & wb_we_i;
	wire [9:0] reg_index = wb_adr_i[11:2];
	wire       lane_lo   = wb_sel_i[0];
	wire       hit_tx    = (reg_index == `BEIS_IDX_TX_CTRL);
	wire       hit_lat   = (reg_index == `BEIS_IDX_LATCHED);
	wire       hit_ien   = (reg_index == `BEIS_IDX_IRQ_EN);
	wire       hit_uc    = (reg_index == `BEIS_IDX_UPD_CTRL);
	wire       wr_tx     = bus_wr & lane_lo & hit_tx;
	wire       wr_lat    = bus_wr & lane_lo & hit_lat;
	wire       wr_ien    = bus_wr & lane_lo & hit_ien;
	wire       wr_uc     = bus_wr & lane_lo & hit_uc;
	wire [2:0] wr_rate   = wb_dat_i[`BEIS_TX_RATE_MSB:`BEIS_TX_RATE_LSB];

	// ============================================================
	// trigger selection and single insertion
	// (R5) source select picks strobe or manual input
	wire trigger = insert_source_select ? manual_insert_input_i : soft_error_strobe;
	// (R2) rising trigger edge arms one error
	wire trigger_rise = trigger & ~trigger_prev;

	// ============================================================
	// rate insertion period, ten to the n
	reg [23:0] rate_period;

	// (R22) period counted in transmit bits
	always @* begin
		case (active_rate)
			3'h1: rate_period = 24'h00000A;
			3'h2: rate_period = 24'h000064;
			3'h3: rate_period = 24'h0003E8;
			3'h4: rate_period = 24'h002710;
			3'h5: rate_period = 24'h0186A0;
			3'h6: rate_period = 24'h0F4240;
			3'h7: rate_period = 24'h989680;
			default: rate_period = 24'h000000;
		endcase
	end

	// (R22) last bit of each period is inverted
	wire rate_hit = (active_rate != 3'h0) & (rate_count == rate_period - `BEIS_ONE_24);

	// (R1) a cleared enable also blocks an armed error
	wire do_single = tx_bit_en_i & single_pending & single_insert_enable;
	wire do_rate   = tx_bit_en_i & rate_hit;

	// ============================================================
	// transmit path
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			tx_data_o  <= 1'b0;
			tx_valid_o <= 1'b0;
		end else begin
			tx_valid_o <= tx_bit_en_i;
			if (tx_bit_en_i) begin
				tx_data_o <= tx_data_i ^ (do_single | do_rate);
			end
		end
	end

	// ============================================================
	// single error arming
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			trigger_prev   <= 1'b0;
			single_pending <= 1'b0;
		end else begin
			trigger_prev <= trigger;
			// (R1) enable clear drops any armed error
			if (!single_insert_enable) begin
				single_pending <= 1'b0;
			// (R4) one armed error per opportunity
			end else if (trigger_rise) begin
				single_pending <= 1'b1;
			end else if (do_single) begin
				single_pending <= 1'b0;
			end
		end
	end

	// ============================================================
	// rate insertion counter
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			active_rate  <= 3'h0;
			pending_rate <= 3'h0;
			rate_reload  <= 1'b0;
			rate_count   <= 24'h000000;
		end else begin
			// (R22) nonzero write starts, busy nonzero write waits for next error, zero write stops at once
			if (wr_tx && (active_rate == 3'h0 || wr_rate == 3'h0)) begin
				active_rate <= wr_rate;
				rate_reload <= 1'b0;
				rate_count  <= 24'h000000;
			end else begin
				if (wr_tx) begin
					pending_rate <= wr_rate;
					rate_reload  <= 1'b1;
				end
				if (do_rate) begin
					rate_count <= 24'h000000;
					if (rate_reload && !wr_tx) begin
						active_rate <= pending_rate;
						rate_reload <= 1'b0;
					end
				end else if (tx_bit_en_i && active_rate != 3'h0) begin
					rate_count <= rate_count + `BEIS_ONE_24;
				end
			end
		end
	end

	// ============================================================
	// update request and snapshot
	// (R8) selected request per update mode
	wire sel_request  = update_mode_select ? global_update_req_i : local_update_request;
	wire request_rise = sel_request & ~request_prev;
	wire request_fall = ~sel_request & request_prev;
	wire count_error  = rx_bit_en_i & rx_bit_error_i & ~pattern_unlocked_i;

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			request_prev             <= 1'b0;
			counter_update_request_o <= 1'b0;
			snap_taken               <= 1'b0;
			counter_update_done      <= 1'b0;
			live_count               <= 24'h000000;
			snap_count               <= 24'h000000;
			error_count_nonzero      <= 1'b0;
			pattern_unlocked         <= 1'b1;
		end else begin
			request_prev             <= sel_request;
			counter_update_request_o <= sel_request;
			snap_taken               <= request_rise;
			// (R11) unlocked status follows the checker
			pattern_unlocked <= pattern_unlocked_i;
			// (R21) snapshot on update, saturate, hold while unlocked
			if (request_rise) begin
				snap_count <= live_count;
				live_count <= count_error ? `BEIS_ONE_24 : 24'h000000;
			// (R21) stop at the top count
			end else if (count_error && live_count != `BEIS_CNT_MAX) begin
				live_count <= live_count + `BEIS_ONE_24;
			end
			// (R9) nonzero sets as count leaves zero
			if (count_error) begin
				error_count_nonzero <= 1'b1;
			// (R10) cleared by an update
			end else if (request_rise) begin
				error_count_nonzero <= 1'b0;
			end
			// (R8) fall of request forces done low
			if (request_fall) begin
				counter_update_done <= 1'b0;
			// (R7) done rises after the snapshot
			end else if (snap_taken && sel_request) begin
				counter_update_done <= 1'b1;
			end
		end
	end

	// ============================================================
	// latched flags
	reg  prev_done;
	reg  prev_nonzero;
	reg  prev_unlocked;
	wire [3:0] flag_set;
	// (R12) latched done on rising done
	assign flag_set[`BEIS_ST_UPD_DONE]    = counter_update_done & ~prev_done;
	// (R13) latched error seen on any bit error
	assign flag_set[`BEIS_ST_ERR_SEEN]    = rx_bit_en_i & rx_bit_error_i;
	// (R14) latched nonzero on rising nonzero
	assign flag_set[`BEIS_ST_CNT_NONZERO] = error_count_nonzero & ~prev_nonzero;
	// (R15) latched unlock on either edge
	assign flag_set[`BEIS_ST_UNLOCKED]    = pattern_unlocked ^ prev_unlocked;
	// (R23) clear only the bits written as one
	wire [3:0] flag_clr = wr_lat ? wb_dat_i[3:0] : 4'h0;


	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			prev_done     <= 1'b0;
			prev_nonzero  <= 1'b0;
			prev_unlocked <= 1'b1;
			latched       <= `BEIS_FLAGS_RESET;
		end else begin
			prev_done     <= counter_update_done;
			prev_nonzero  <= error_count_nonzero;
			prev_unlocked <= pattern_unlocked;
			// (R23) write one clears, a new set wins
			latched <= (latched & ~flag_clr) | flag_set;
		end
	end

	// ============================================================
	// interrupt
	wire [3:0] irq_hit = latched & irq_enable;
	// (R16) update done needs only its own enable
	wire       irq_done   = irq_hit[`BEIS_ST_UPD_DONE];
	// (R17) (R18) (R19) status flags also need the port gate
	wire       irq_status = port_status_irq_gate & (irq_hit[`BEIS_ST_ERR_SEEN] |
		irq_hit[`BEIS_ST_CNT_NONZERO] | irq_hit[`BEIS_ST_UNLOCKED]);

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			// (R24) one request for all enabled flags, status flags only with the port gate
			irq_o <= irq_done | irq_status;
		end
	end

	// ============================================================
	// control register writes
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			insert_source_select <= 1'b0;
			soft_error_strobe    <= 1'b0;
			single_insert_enable <= 1'b0;
			insert_rate_exponent <= 3'h0;
			local_update_request <= 1'b0;
			update_mode_select   <= 1'b0;
			port_status_irq_gate <= 1'b0;
			irq_enable           <= 4'h0;
		end else begin
			if (wr_tx) begin
				// (R6) select change may make one trigger edge
				insert_source_select <= wb_dat_i[`BEIS_TX_SRC_SEL];
				// (R3) each error needs a fresh strobe rise
				soft_error_strobe    <= wb_dat_i[`BEIS_TX_SOFT_STROBE];
				single_insert_enable <= wb_dat_i[`BEIS_TX_SINGLE_EN];
				insert_rate_exponent <= wr_rate;
			end
			if (wr_uc) begin
				local_update_request <= wb_dat_i[`BEIS_UC_LOCAL_REQ];
				update_mode_select   <= wb_dat_i[`BEIS_UC_MODE_SEL];
				port_status_irq_gate <= wb_dat_i[`BEIS_UC_PORT_GATE];
			end
			if (wr_ien) begin
				irq_enable <= wb_dat_i[3:0];
			end
		end
	end

	// ============================================================
	// read mux
	reg [15:0] rd_word;
	always @* begin
		rd_word = 16'h0000;
		if (hit_tx) begin
			rd_word = {10'h000, insert_rate_exponent, single_insert_enable,
				soft_error_strobe, insert_source_select};
		end else if (reg_index == `BEIS_IDX_STATUS) begin
			rd_word = {12'h000, counter_update_done, 1'b0,
				error_count_nonzero, pattern_unlocked};
		end else if (hit_lat) begin
			rd_word = {12'h000, latched};
		end else if (hit_ien) begin
			rd_word = {12'h000, irq_enable};
		// (R20) low 16 and high 8 bits of the count
		end else if (reg_index == `BEIS_IDX_CNT_LOW) begin
			rd_word = snap_count[15:0];
		// (R20) upper 8 bits from the same snapshot
		end else if (reg_index == `BEIS_IDX_CNT_HIGH) begin
			rd_word = {8'h00, snap_count[23:16]};
		end else if (hit_uc) begin
			rd_word = {13'h0000, port_status_irq_gate, update_mode_select,
				local_update_request};
		end
	end

	// ============================================================
	// wishbone answer
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			// read data stands only with ack
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= {16'h0000, rd_word};
			end else begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

endmodule

//--- beis_framer_model.sv
// framer data path model sending pattern bits and counting inverted ones
module beis_framer_model (
	input wire		ref_clk_i,
	input wire		reset_i,
	input wire		run_i,
	output logic		tx_data_o,
	output logic		tx_bit_en_o,
	input wire		tx_line_i,
	input wire		tx_valid_i,
	output logic [7:0]	flips_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]	lfsr;
	logic [1:0]	ph;
	logic		sent;
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			lfsr <= 4'h1;
			ph <= 2'h0;
			sent <= 1'b0;
			tx_bit_en_o <= 1'b0;
			tx_data_o <= 1'b0;
			flips_o <= 8'h00;
		end else begin
			ph <= ph + 2'h1;
			tx_bit_en_o <= run_i && ph == 2'h3;
			if (run_i && ph == 2'h3) begin
				lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
				tx_data_o <= lfsr[0];
				sent <= lfsr[0];
			end else
				tx_data_o <= ~tx_data_o;
			if (tx_valid_i && tx_line_i !== sent) flips_o <= flips_o + 8'h01;
		end
	end
endmodule

//--- beis_map.vh
// register indices, field positions, reset values and counts for the pattern checker block
`ifndef BEIS_MAP_VH
`define BEIS_MAP_VH

// ============================================================
// register indices (byte address is four times the index)
`define BEIS_IDX_TX_CTRL      10'h068
`define BEIS_IDX_STATUS       10'h06C
`define BEIS_IDX_LATCHED      10'h06E
`define BEIS_IDX_IRQ_EN       10'h070
`define BEIS_IDX_CNT_LOW      10'h074
`define BEIS_IDX_CNT_HIGH     10'h076
`define BEIS_IDX_UPD_CTRL     10'h080

// ============================================================
// transmit insertion control fields
`define BEIS_TX_SRC_SEL       0
`define BEIS_TX_SOFT_STROBE   1
`define BEIS_TX_SINGLE_EN     2
`define BEIS_TX_RATE_LSB      3
`define BEIS_TX_RATE_MSB      5
`define BEIS_TX_CTRL_RESET    6'h00

// ============================================================
// status and latched status fields
`define BEIS_ST_UNLOCKED      0
`define BEIS_ST_CNT_NONZERO   1
`define BEIS_ST_ERR_SEEN      2
`define BEIS_ST_UPD_DONE      3
`define BEIS_FLAGS_RESET      4'h0

// ============================================================
// update control fields
`define BEIS_UC_LOCAL_REQ     0
`define BEIS_UC_MODE_SEL      1
`define BEIS_UC_PORT_GATE     2
`define BEIS_UC_RESET         3'h0

// ============================================================
// counter limits
`define BEIS_CNT_MAX          24'hFFFFFF
`define BEIS_ONE_24           24'h000001

`endif

//--- beis_props.sv
// concurrent checks on the pattern checker block ports
`include "beis_map.vh"
module beis_props (
	input wire		ref_clk_i,
	input wire		reset_i,
	input wire		wb_cyc_i,
	input wire		wb_stb_i,
	input wire		wb_we_i,
	input wire [31:0]	wb_adr_i,
	input wire [3:0]	wb_sel_i,
	input wire [31:0]	wb_dat_i,
	input wire [31:0]	wb_dat_o,
	input wire		wb_ack_o,
	input wire		tx_data_i,
	input wire		tx_bit_en_i,
	input wire		tx_data_o,
	input wire		tx_valid_o,
	input wire		manual_insert_input_i,
	input wire		global_update_req_i,
	input wire		pattern_unlocked_i,
	input wire		rx_bit_en_i,
	input wire		rx_bit_error_i,
	input wire		counter_update_request_o,
	input wire		irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ============================================================
	// shadow copies of the control registers seen on the bus
	logic [5:0]	ctl;
	logic [2:0]	upd;
	logic [3:0]	ien;
	wire		wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctl <= 6'h00;
			upd <= 3'h0;
			ien <= 4'h0;
		end else if (wr) begin
			if (wb_adr_i[11:2] == `BEIS_IDX_TX_CTRL) ctl <= wb_dat_i[5:0];
			if (wb_adr_i[11:2] == `BEIS_IDX_UPD_CTRL) upd <= wb_dat_i[2:0];
			if (wb_adr_i[11:2] == `BEIS_IDX_IRQ_EN) ien <= wb_dat_i[3:0];
		end
	end
	// ============================================================
	// properties
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack lasted more than one cycle");
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("access not answered next cycle");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data not zero outside ack");
	tx_hold_a: assert property (!tx_bit_en_i |=> $stable(tx_data_o))
		else $error("tx data changed without a bit");
	single_off_a: assert property (tx_bit_en_i && !ctl[2] && ctl[5:3] == 3'h0
		|=> tx_data_o == $past(tx_data_i)) else $error("bit inverted while insert off");
	upd_mode_a: assert property (upd[1] |=> counter_update_request_o == $past(global_update_req_i))
		else $error("update request not following global request");
	irq_none_a: assert property (ien == 4'h0 |=> !irq_o)
		else $error("irq with all enables off");
	irq_gate_a: assert property (!ien[3] && !upd[2] |=> !irq_o)
		else $error("status irq without port gate");
endmodule
bind beis_core beis_props u_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.tx_data_i(tx_data_i), .tx_bit_en_i(tx_bit_en_i), .tx_data_o(tx_data_o),
	.tx_valid_o(tx_valid_o), .manual_insert_input_i(manual_insert_input_i),
	.global_update_req_i(global_update_req_i), .pattern_unlocked_i(pattern_unlocked_i),
	.rx_bit_en_i(rx_bit_en_i), .rx_bit_error_i(rx_bit_error_i),
	.counter_update_request_o(counter_update_request_o), .irq_o(irq_o));

//--- tb_bert_error_insert_and_status.sv
// self-checking bench for the pattern checker block
`include "beis_map.vh"
module tb_bert_error_insert_and_status;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, man = 0, glb = 0;
	logic unl = 0, rxe = 0, rxr = 0, run = 1;
	logic [31:0]	adr = 0, wdat = 0, q;
	logic [7:0]	base;
	wire [31:0]	rdat;
	wire [7:0]	flips;
	wire		ack, txd, txen, txo, txv, upq, irq;
	int		n_fail = 0, checks = 0, cyc_cnt = 0;
	always #50 clk = ~clk;
	beis_core dut (.ref_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .tx_data_i(txd), .tx_bit_en_i(txen), .tx_data_o(txo),
		.tx_valid_o(txv), .manual_insert_input_i(man), .global_update_req_i(glb),
		.pattern_unlocked_i(unl), .rx_bit_en_i(rxe), .rx_bit_error_i(rxr),
		.counter_update_request_o(upq), .irq_o(irq));
	beis_framer_model u_frm (.ref_clk_i(clk), .reset_i(rst), .run_i(run), .tx_data_o(txd),
		.tx_bit_en_o(txen), .tx_line_i(txo), .tx_valid_i(txv), .flips_o(flips));
	// ============================================================
	// helpers
	task test_done;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			n_fail++;
			test_done;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [9:0] ix, input logic [15:0] d);
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= {20'h00000, ix, 2'h0}; wdat <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task wr(input logic [9:0] ix, input logic [15:0] d); wb(1'b1, ix, d); endtask
	task rd(input logic [9:0] ix, input logic [31:0] e); wb(1'b0, ix, 16'h0000); chk(q, e); endtask
	task fl(input logic [7:0] e);
		repeat (3) begin do @(posedge clk); while (txv !== 1'b1); end
		chk({24'h000000, flips}, {24'h000000, e});
	endtask
	task errs(input int n);
		repeat (n) begin
			@(posedge clk); rxe <= 1; rxr <= 1;
			@(posedge clk); rxe <= 0; rxr <= 0;
		end
	endtask
	// ============================================================
	// scenarios
	task t_regs;
		rd(`BEIS_IDX_IRQ_EN, 32'h0);
		rd(`BEIS_IDX_CNT_LOW, 32'h0);
		rd(10'h07E, 32'h0);
		wr(`BEIS_IDX_IRQ_EN, 16'h0005); rd(`BEIS_IDX_IRQ_EN, 32'h5);
		wr(`BEIS_IDX_IRQ_EN, 16'h0000);
		wr(`BEIS_IDX_STATUS, 16'hFFFF); rd(`BEIS_IDX_STATUS, 32'h0);
	endtask
	task t_insert;
		base = flips;
		wr(`BEIS_IDX_TX_CTRL, 16'h0002); fl(base);
		wr(`BEIS_IDX_TX_CTRL, 16'h0000); wr(`BEIS_IDX_TX_CTRL, 16'h0004);
		wr(`BEIS_IDX_TX_CTRL, 16'h0006); fl(base + 8'h01);
		wr(`BEIS_IDX_TX_CTRL, 16'h0006); fl(base + 8'h01);
		@(posedge clk); run <= 0;
		repeat (6) @(posedge clk);
		wr(`BEIS_IDX_TX_CTRL, 16'h0004); wr(`BEIS_IDX_TX_CTRL, 16'h0006);
		wr(`BEIS_IDX_TX_CTRL, 16'h0004); wr(`BEIS_IDX_TX_CTRL, 16'h0006);
		@(posedge clk); run <= 1;
		fl(base + 8'h02);
		wr(`BEIS_IDX_TX_CTRL, 16'h0004); wr(`BEIS_IDX_TX_CTRL, 16'h0005);
		@(posedge clk); man <= 1;
		repeat (3) @(posedge clk); man <= 0;
		fl(base + 8'h03);
		wr(`BEIS_IDX_TX_CTRL, 16'h0007); fl(base + 8'h03);
		wr(`BEIS_IDX_TX_CTRL, 16'h0005); wr(`BEIS_IDX_TX_CTRL, 16'h0000);
	endtask
	task t_rate;
		@(posedge clk); run <= 0;
		repeat (6) @(posedge clk);
		base = flips;
		wr(`BEIS_IDX_TX_CTRL, 16'h0008);
		@(posedge clk); run <= 1;
		repeat (25) begin do @(posedge clk); while (txv !== 1'b1); end
		@(posedge clk); run <= 0;
		repeat (6) @(posedge clk);
		wr(`BEIS_IDX_TX_CTRL, 16'h0000);
		chk({24'h000000, flips}, {24'h000000, base + 8'h02});
		@(posedge clk); run <= 1;
	endtask
	task t_global;
		wr(`BEIS_IDX_IRQ_EN, 16'h0008);
		wr(`BEIS_IDX_UPD_CTRL, 16'h0002);
		@(posedge clk); glb <= 1;
		repeat (4) @(posedge clk);
		chk({31'h0, upq}, 32'h1);
		rd(`BEIS_IDX_STATUS, 32'h8);
		chk({31'h0, irq}, 32'h1);
		@(posedge clk); glb <= 0;
		repeat (4) @(posedge clk);
		rd(`BEIS_IDX_STATUS, 32'h0);
		wr(`BEIS_IDX_UPD_CTRL, 16'h0000);
	endtask
	task t_count;
		wr(`BEIS_IDX_LATCHED, 16'h000F);
		errs(3);
		rd(`BEIS_IDX_STATUS, 32'h2);
		rd(`BEIS_IDX_LATCHED, 32'h6);
		wr(`BEIS_IDX_IRQ_EN, 16'h0007); rd(`BEIS_IDX_CNT_HIGH, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(`BEIS_IDX_UPD_CTRL, 16'h0004); rd(`BEIS_IDX_CNT_HIGH, 32'h0);
		chk({31'h0, irq}, 32'h1);
		wr(`BEIS_IDX_UPD_CTRL, 16'h0005);
		rd(`BEIS_IDX_CNT_LOW, 32'h3);
		rd(`BEIS_IDX_STATUS, 32'h8);
		rd(`BEIS_IDX_LATCHED, 32'hE);
		wr(`BEIS_IDX_LATCHED, 16'h000F); rd(`BEIS_IDX_LATCHED, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(`BEIS_IDX_UPD_CTRL, 16'h0004);
	endtask
	task t_unlock;
		@(posedge clk); unl <= 1;
		errs(2);
		wr(`BEIS_IDX_UPD_CTRL, 16'h0005);
		rd(`BEIS_IDX_CNT_LOW, 32'h0);
		rd(`BEIS_IDX_STATUS, 32'h9);
		rd(`BEIS_IDX_LATCHED, 32'hD);
		wr(`BEIS_IDX_LATCHED, 16'h000F);
		@(posedge clk); unl <= 0;
		wr(`BEIS_IDX_UPD_CTRL, 16'h0000);
		rd(`BEIS_IDX_LATCHED, 32'h1);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		t_regs;
		t_insert;
		t_rate;
		t_global;
		t_count;
		t_unlock;
		test_done;
	end
endmodule
